// *** cgp_clock_control.sv ***
// clock control top: register file, clock output select and warm-up timer
// ****************************************************************
// Summary of operation
// - five control words at byte offsets 0x0 to 0x10 from the block base.
// - two-bit select drives clock pin: low-speed, system/2, system, prescaler.
// - peripheral clock comes from geared clock at 0, undivided high-speed at 1.
// - prescaler divides peripheral clock by 1 to 32; codes 110 and 111 reserved.
// - gear code 000 undivided, 100/101/110 divide by 2/4/8, others reserved.
// - writing 1 to warm-up start launches the timer; writing 0 does nothing.
// - warm-up busy reads 1 while counting, 0 once warm-up completes.
// - warm-up source bit picks high-speed (0) or low-speed (1) oscillator.
// - pll run bit clears at reset; software sets it to run the PLL.
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
`include "cgp_regs.svh"
module cgp_clock_control
  import cgp_pkg::*;
(
  input  wire logic        MCLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        HS_TICK_IN,
  input  wire logic        LS_TICK_IN,
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [31:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [31:0] RDATA_OUT,
  output logic             CLK_OUT_PIN_OUT,
  output logic             PERIPH_EN_OUT,
  output logic             PRESC_EN_OUT,
  output logic             PLL_RUN_OUT,
  output logic             HS_OSC_ENABLE_OUT,
  output logic             LS_OSC_ENABLE_OUT,
  output logic             WARMUP_BUSY_OUT
);
  cgp_div_if dvi ();

  cgp_word_t   sysctl;
  cgp_word_t   oscctl;
  cgp_word_t   stby;
  cgp_word_t   pllsel;
  cgp_word_t   cksel;
  logic        warmup_busy;
  logic [18:0] wu_cnt;
  logic        wu_src_latched;

  wire         sel_sys;
  wire         sel_osc;
  wire         sel_stby;
  wire         sel_pll;
  wire         sel_ck;
  wire         warmup_start;
  wire         wu_tick;
  wire  [1:0]  clk_out_select;
  wire  [2:0]  warmup_time;
  wire  [4:0]  wu_exp;
  wire  [18:0] wu_limit;
  wire         wu_done;
  cgp_word_t   osc_view;
  cgp_word_t   rd_mux;
  logic        next_pin;

  // ****************************************************************
  // address decode
  // ****************************************************************
  assign sel_sys  = ADDR_IN == `CGP_OFS_SYSCTL;
  assign sel_osc  = ADDR_IN == `CGP_OFS_OSCCTL;
  assign sel_stby = ADDR_IN == `CGP_OFS_STBY;
  assign sel_pll  = ADDR_IN == `CGP_OFS_PLLSEL;
  assign sel_ck   = ADDR_IN == `CGP_OFS_CKSEL;
  assign warmup_start = WR_IN && sel_osc && WDATA_IN[`CGP_WSTART_BIT];

  // ****************************************************************
  // field views
  // ****************************************************************
  assign dvi.gear              = sysctl[`CGP_GEAR_LSB +: 3];
  assign dvi.prescale_select   = sysctl[`CGP_PRESCALE_SELECT_LSB +: 3];
  assign dvi.periph_src_select = sysctl[`CGP_PERIPH_SRC_SELECT_BIT];
  assign clk_out_select        = sysctl[`CGP_COSEL_LSB +: 2];
  assign warmup_time           = oscctl[`CGP_WTIME_LSB +: 3];

  // busy is live state, start is write-only: both read back from here only
  assign osc_view = (oscctl & ~32'h0000_0003) | {30'h0, warmup_busy, 1'b0};

  // unmapped offsets and unused bits read as zero
  assign rd_mux = sel_sys  ? sysctl :
                  sel_osc  ? osc_view :
                  sel_stby ? stby :
                  sel_pll  ? pllsel :
                  sel_ck   ? cksel : 32'h0000_0000;

  // ****************************************************************
  // warm-up timer: 2**n cycles of the chosen oscillator tick
  // ****************************************************************
  assign wu_tick  = wu_src_latched ? LS_TICK_IN : HS_TICK_IN;
  assign wu_exp   = !wu_src_latched ? (`CGP_WU_HS_BASE + {2'h0, warmup_time}) :
                    warmup_time[2] ? (`CGP_WU_LS_HI_BASE + {2'h0, warmup_time}) :
                    (`CGP_WU_LS_BASE + {2'h0, warmup_time});
  assign wu_limit = (warmup_time == 3'h0) ? 19'h0_0000 : (19'h0_0001 << wu_exp);
  assign wu_done  = wu_tick && (wu_cnt + 19'h0_0001 >= wu_limit);

  always_comb
  begin
    next_pin = 1'b0;
    unique case (cgp_out_e'(clk_out_select))
      CGP_OUT_LS:       next_pin = LS_TICK_IN;
      CGP_OUT_SYS_HALF: next_pin = dvi.sys_half_en;
      CGP_OUT_SYS:      next_pin = ~CLK_OUT_PIN_OUT;
      CGP_OUT_PRESC:    next_pin = dvi.presc_en;
    endcase
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  always_ff @(posedge MCLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      sysctl <= `CGP_SYSCTL_RST;
      oscctl <= `CGP_OSCCTL_RST;
      stby   <= `CGP_STBY_RST;
      pllsel <= `CGP_PLLSEL_RST;
      cksel  <= `CGP_CKSEL_RST;
    end
    else if (WR_IN)
    begin
      if (sel_sys)
        sysctl <= WDATA_IN & `CGP_SYSCTL_MASK;
      if (sel_osc)
        oscctl <= WDATA_IN & `CGP_OSCCTL_MASK;
      if (sel_stby)
        stby <= WDATA_IN & `CGP_STBY_MASK;
      if (sel_pll)
        pllsel <= WDATA_IN & `CGP_PLLSEL_MASK;
      if (sel_ck)
        cksel <= WDATA_IN & `CGP_CKSEL_MASK;
    end
  end

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      warmup_busy    <= 1'b0;
      wu_cnt         <= 19'h0_0000;
      wu_src_latched <= 1'b0;
    end
    else
    begin
      if (warmup_start)
      begin
        // source is fixed at the start; the time code is read live, so a later write can still change the limit
        wu_src_latched <= WDATA_IN[`CGP_WSRC_BIT];
        wu_cnt         <= 19'h0_0000;
        warmup_busy    <= 1'b1;
      end
      else if (warmup_busy)
      begin
        if (wu_limit == 19'h0_0000 || wu_done)
          warmup_busy <= 1'b0;
        else if (wu_tick)
          wu_cnt <= wu_cnt + 19'h0_0001;
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge MCLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      RDATA_OUT         <= 32'h0000_0000;
      CLK_OUT_PIN_OUT   <= 1'b0;
      PERIPH_EN_OUT     <= 1'b0;
      PRESC_EN_OUT      <= 1'b0;
      PLL_RUN_OUT       <= 1'b0;
      HS_OSC_ENABLE_OUT <= 1'b1;
      LS_OSC_ENABLE_OUT <= 1'b1;
      WARMUP_BUSY_OUT   <= 1'b0;
    end
    else
    begin
      RDATA_OUT         <= RD_IN ? rd_mux : 32'h0000_0000;
      CLK_OUT_PIN_OUT   <= next_pin;
      PERIPH_EN_OUT     <= dvi.periph_en;
      PRESC_EN_OUT      <= dvi.presc_en;
      PLL_RUN_OUT       <= oscctl[`CGP_PLLRUN_BIT];
      HS_OSC_ENABLE_OUT <= oscctl[`CGP_HSEN_BIT];
      LS_OSC_ENABLE_OUT <= oscctl[`CGP_LSEN_BIT];
      WARMUP_BUSY_OUT   <= warmup_busy;
    end
  end

  cgp_divider u_div (
    .MCLK_IN    (MCLK_IN),
    .RESET_N_IN (RESET_N_IN),
    .dv         (dvi.div)
  );

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence start_write;
    warmup_start;
  endsequence
  sequence busy_shown;
    warmup_busy ##1 WARMUP_BUSY_OUT;
  endsequence

  warmup_start_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    start_write |=> busy_shown)
    else $error("warm-up start did not raise busy");
  zero_write_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (WR_IN && sel_osc && !WDATA_IN[0] && !warmup_busy) |=> !warmup_busy)
    else $error("writing zero started warm-up");
  busy_read_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (RD_IN && sel_osc) |=> (RDATA_OUT[1] == $past(warmup_busy)) && !RDATA_OUT[0])
    else $error("warm-up status read wrong");
  unmapped_read_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (RD_IN && !(sel_sys || sel_osc || sel_stby || sel_pll || sel_ck))
      |=> RDATA_OUT == 32'h0000_0000)
    else $error("unmapped read not zero");
  sys_read_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (RD_IN && sel_sys) |=> (RDATA_OUT[31:18] == 14'h0000) && (RDATA_OUT == $past(sysctl)))
    else $error("system control readback wrong");
  pin_sys_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (clk_out_select == 2'h2) [*2] |-> CLK_OUT_PIN_OUT != $past(CLK_OUT_PIN_OUT))
    else $error("clock pin not toggling on system clock");
  pll_follow_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (WR_IN && sel_osc) |=> ##1 PLL_RUN_OUT == $past(WDATA_IN[2], 2))
    else $error("pll run not following write");
  periph_fc_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    dvi.periph_src_select [*3] |-> PERIPH_EN_OUT)
    else $error("undivided peripheral clock gapped");
  src_latch_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    warmup_start |=> wu_src_latched == $past(WDATA_IN[3]))
    else $error("warm-up source not taken");
endmodule
`default_nettype wire

// *** cgp_regs.svh ***
// register offsets, field positions, reset values and timing counts of the clock control block
`ifndef CGP_REGS_SVH
`define CGP_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define CGP_OFS_SYSCTL     8'h00
`define CGP_OFS_OSCCTL     8'h04
`define CGP_OFS_STBY       8'h08
`define CGP_OFS_PLLSEL     8'h0C
`define CGP_OFS_CKSEL      8'h10

// ****************************************************************
// field positions
// ****************************************************************
`define CGP_GEAR_LSB       0
`define CGP_PRESCALE_SELECT_LSB       8
`define CGP_PERIPH_SRC_SELECT_BIT      12
`define CGP_COSEL_LSB      16
`define CGP_WSTART_BIT     0
`define CGP_WBUSY_BIT      1
`define CGP_PLLRUN_BIT     2
`define CGP_WSRC_BIT       3
`define CGP_WTIME_LSB      4
`define CGP_HSEN_BIT       8
`define CGP_LSEN_BIT       9

// ****************************************************************
// writable masks and reset values
// ****************************************************************
`define CGP_SYSCTL_MASK    32'h0003_1707
`define CGP_SYSCTL_RST     32'h0001_0000
`define CGP_OSCCTL_MASK    32'h0000_337C
`define CGP_OSCCTL_RST     32'h0000_0310
`define CGP_STBY_MASK      32'h0003_0307
`define CGP_STBY_RST       32'h0000_0100
`define CGP_PLLSEL_MASK    32'h0000_0001
`define CGP_PLLSEL_RST     32'h0000_0000
`define CGP_CKSEL_MASK     32'h0000_0003
`define CGP_CKSEL_RST      32'h0000_0000

// ****************************************************************
// warm-up exponent bases: n = base + time code, count 2**n
// ****************************************************************
`define CGP_WU_HS_BASE     5'd9
`define CGP_WU_LS_BASE     5'd5
`define CGP_WU_LS_HI_BASE  5'd11

`endif

// *** cgp_pkg.sv ***
// types shared by the clock control block
package cgp_pkg;
  typedef enum logic [1:0] {CGP_OUT_LS, CGP_OUT_SYS_HALF, CGP_OUT_SYS, CGP_OUT_PRESC} cgp_out_e;
  typedef logic [31:0] cgp_word_t;
endpackage

// *** cgp_div_if.sv ***
// interface joining the top to its divider chain
`timescale 1ns/1ps
`default_nettype none
interface cgp_div_if;
  logic [2:0] gear;
  logic       periph_src_select;
  logic [2:0] prescale_select;
  logic       gear_en;
  logic       periph_en;
  logic       presc_en;
  logic       sys_half_en;
  modport ctl (output gear, periph_src_select, prescale_select,
               input gear_en, periph_en, presc_en, sys_half_en);
  modport div (input gear, periph_src_select, prescale_select,
               output gear_en, periph_en, presc_en, sys_half_en);
endinterface
`default_nettype wire

// *** cgp_divider.sv ***
// divider chain making the geared, peripheral and prescaler clock enables
`timescale 1ns/1ps
`default_nettype none
`include "cgp_regs.svh"
module cgp_divider
  import cgp_pkg::*;
(
  input  wire logic MCLK_IN,
  input  wire logic RESET_N_IN,
  cgp_div_if.div    dv
);
  logic [2:0] gear_cnt;
  logic [4:0] presc_cnt;
  logic       half_tog;
  wire        gear_hit;
  wire  [2:0] gear_mask;
  wire  [4:0] presc_mask;
  wire        periph_tick;

  // ****************************************************************
  // gear: codes 100 to 110 divide by 2 << low bits, reserved codes pass fc
  // ****************************************************************
  assign gear_mask = (dv.gear[2] && dv.gear[1:0] != 2'h3) ?
                     ((3'h2 << dv.gear[1:0]) - 3'h1) : 3'h0;
  assign gear_hit  = (gear_cnt & gear_mask) == 3'h0;
  assign periph_tick = dv.periph_src_select ? 1'b1 : gear_hit;
  // reserved prescaler codes fall back to divide by 32 to stay bounded
  assign presc_mask = (dv.prescale_select > 3'h5) ? 5'h1F :
                      ((5'h01 << dv.prescale_select) - 5'h01);

  always_ff @(posedge MCLK_IN)
  begin
    if (!RESET_N_IN)
    begin
      gear_cnt     <= 3'h0;
      presc_cnt    <= 5'h00;
      half_tog     <= 1'b0;
      dv.gear_en   <= 1'b0;
      dv.periph_en <= 1'b0;
      dv.presc_en  <= 1'b0;
      dv.sys_half_en <= 1'b0;
    end
    else
    begin
      gear_cnt     <= gear_cnt + 3'h1;
      half_tog     <= ~half_tog;
      dv.gear_en   <= gear_hit;
      dv.periph_en <= periph_tick;
      dv.sys_half_en <= half_tog;
      if (periph_tick)
        presc_cnt <= presc_cnt + 5'h01;
      dv.presc_en  <= periph_tick && ((presc_cnt & presc_mask) == 5'h00);
    end
  end

  gear_div_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    (dv.gear == 3'h4) [*2] |=> (dv.gear_en != $past(dv.gear_en)))
    else $error("geared enable not halving");
  presc_undiv_a: assert property (@(posedge MCLK_IN) disable iff (!RESET_N_IN)
    ($past(RESET_N_IN) && $past(dv.prescale_select) == 3'h0 && $past(periph_tick))
      |-> dv.presc_en)
    else $error("undivided prescaler missed a tick");
endmodule
`default_nettype wire

// *** cgp_tb.sv ***
// self-checking testbench of the clock control block
`timescale 1ns/1ps
`default_nettype none
`include "cgp_regs.svh"
`define CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      miscompares++; \
      $display("Error %s expected %h seen %h", nm, exp, got); \
    end \
  end
module testbench
  import cgp_pkg::*;
;
  // ****************************************************************
  // signals and tables
  // ****************************************************************
  localparam logic [7:0] OFS [5] = '{`CGP_OFS_SYSCTL, `CGP_OFS_OSCCTL, `CGP_OFS_STBY,
                                     `CGP_OFS_PLLSEL, `CGP_OFS_CKSEL};
  localparam cgp_word_t  RST [5] = '{`CGP_SYSCTL_RST, `CGP_OSCCTL_RST, `CGP_STBY_RST,
                                     `CGP_PLLSEL_RST, `CGP_CKSEL_RST};
  localparam cgp_word_t  MSK [5] = '{`CGP_SYSCTL_MASK, `CGP_OSCCTL_MASK, `CGP_STBY_MASK,
                                     `CGP_PLLSEL_MASK, `CGP_CKSEL_MASK};
  localparam int         GEAR_CODE [4] = '{0, 4, 5, 6};
  localparam int         GEAR_CNT  [4] = '{128, 64, 32, 16};
  localparam int         PIN_CNT   [4] = '{32, 64, 64, 32};
  // gear and prescaler codes kept legal, start bit clear
  localparam cgp_word_t  WR_ALL [5] = '{32'hFFFF_FDFE, 32'hFFFF_FFFE, 32'hFFFF_FFFF,
                                        32'hFFFF_FFFF, 32'hFFFF_FFFF};
  logic        mclk;
  logic        rst_n;
  logic        hs_tick = 1'b0;
  logic        ls_tick = 1'b0;
  logic        hs_on;
  logic        ls_on;
  logic [1:0]  tcnt = 2'h0;
  logic [7:0]  addr;
  cgp_word_t   wdata;
  logic        wr;
  logic        rd;
  cgp_word_t   rdata;
  logic        pin;
  logic        periph_en;
  logic        presc_en;
  logic        pll_run;
  logic        hs_en;
  logic        ls_en;
  logic        busy;
  int          miscompares;
  int          compares;
  int          k;

  cgp_clock_control u_cgp_clock_control (
    .MCLK_IN           (mclk),
    .RESET_N_IN        (rst_n),
    .HS_TICK_IN        (hs_tick),
    .LS_TICK_IN        (ls_tick),
    .ADDR_IN           (addr),
    .WDATA_IN          (wdata),
    .WR_IN             (wr),
    .RD_IN             (rd),
    .RDATA_OUT         (rdata),
    .CLK_OUT_PIN_OUT   (pin),
    .PERIPH_EN_OUT     (periph_en),
    .PRESC_EN_OUT      (presc_en),
    .PLL_RUN_OUT       (pll_run),
    .HS_OSC_ENABLE_OUT (hs_en),
    .LS_OSC_ENABLE_OUT (ls_en),
    .WARMUP_BUSY_OUT   (busy)
  );

  // ****************************************************************
  // clock and oscillator ticks
  // ****************************************************************
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // high-speed ticks every 2nd cycle, low-speed every 4th, so the two rates can be told apart
  always @(posedge mclk)
  begin
    tcnt    <= tcnt + 2'h1;
    hs_tick <= hs_on & tcnt[0];
    ls_tick <= ls_on & (tcnt == 2'h3);
  end

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic wr_reg(input logic [7:0] a, input cgp_word_t d);
    @(posedge mclk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  task automatic chk_reg(input logic [7:0] a, input cgp_word_t e);
    cgp_word_t v;
    @(posedge mclk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd   <= 1'b0;
    #1;
    v = rdata;
    `CHK("register", e, v)
  endtask

  // counts pulses over 128 cycles; one pulse of slack covers the divider phase
  task automatic measure(input int which, input int e);
    int n;
    n = 0;
    repeat (8) @(posedge mclk);
    repeat (128)
    begin
      @(posedge mclk);
      #1;
      n += (which == 0) ? periph_en : (which == 1) ? presc_en : pin;
    end
    `CHK("pulse count", 1'b1, (n >= e - 1 && n <= e + 1))
  endtask

  task automatic wait_idle();
    k = 0;
    while (busy !== 1'b0 && k < 400)
    begin
      @(posedge mclk);
      #1;
      k++;
    end
  endtask

  task automatic chk_reset();
    for (int i = 0; i < 5; i++)
      chk_reg(OFS[i], RST[i]);
    chk_reg(8'h14, 32'h0000_0000);
    `CHK("pll run", 1'b0, pll_run)
    `CHK("osc enables", 2'h3, {hs_en, ls_en})
    `CHK("warm-up busy", 1'b0, busy)
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    {rst_n, addr, wdata, wr, rd} = '0;
    {hs_on, ls_on} = 2'h3;
    compares = 0;
    miscompares = 0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    chk_reset();
    // start bit left clear so no warm-up begins here
    for (int i = 0; i < 5; i++)
      wr_reg(OFS[i], WR_ALL[i]);
    wr_reg(8'h14, 32'hFFFF_FFFF);
    for (int i = 0; i < 5; i++)
      chk_reg(OFS[i], WR_ALL[i] & MSK[i]);
    chk_reg(8'h14, 32'h0000_0000);
    `CHK("pll run", 1'b1, pll_run)
    wr_reg(OFS[1], 32'h0000_0000);
    repeat (2) @(posedge mclk);
    #1;
    `CHK("pll run", 1'b0, pll_run)
    `CHK("osc enables", 2'h0, {hs_en, ls_en})
    `CHK("warm-up busy", 1'b0, busy)
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    chk_reset();
    wr_reg(OFS[1], 32'h0000_0310);
    repeat (3) @(posedge mclk);
    #1;
    `CHK("warm-up busy", 1'b0, busy)
    // high-speed warm-up: 2**10 ticks, about 2048 cycles
    ls_on <= 1'b0;
    wr_reg(OFS[1], 32'h0000_0311);
    repeat (3) @(posedge mclk);
    #1;
    `CHK("warm-up busy", 1'b1, busy)
    chk_reg(OFS[1], 32'h0000_0312);
    repeat (1890) @(posedge mclk);
    wait_idle();
    `CHK("hs warm-up span", 1'b1, (k >= 135 && k <= 175))
    chk_reg(OFS[1], 32'h0000_0310);
    // low-speed warm-up: 2**6 ticks, high-speed ticks stopped
    hs_on <= 1'b0;
    ls_on <= 1'b1;
    wr_reg(OFS[1], 32'h0000_0319);
    repeat (3) @(posedge mclk);
    #1;
    `CHK("warm-up busy", 1'b1, busy)
    wait_idle();
    `CHK("ls warm-up span", 1'b1, (k >= 238 && k <= 272))
    hs_on <= 1'b1;
    // time code 000: busy shows for a single cycle
    wr_reg(OFS[1], 32'h0000_0301);
    @(posedge mclk);
    #1;
    `CHK("no warm-up busy", 1'b1, busy)
    @(posedge mclk);
    #1;
    `CHK("no warm-up done", 1'b0, busy)
    for (int g = 0; g < 4; g++)
    begin
      wr_reg(OFS[0], GEAR_CODE[g]);
      measure(0, GEAR_CNT[g]);
    end
    wr_reg(OFS[0], 32'h0000_1004);
    measure(0, 128);
    for (int p = 0; p < 6; p++)
    begin
      wr_reg(OFS[0], 32'h0000_1000 | (p << 8));
      measure(1, 128 >> p);
    end
    for (int s = 0; s < 4; s++)
    begin
      wr_reg(OFS[0], 32'h0000_1200 | (s << 16));
      measure(2, PIN_CNT[s]);
    end
    results();
  end

  // whole run is near 4500 cycles; this span leaves wide margin
  initial
  begin
    #400000;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
